// ---- core/bcs_map.vh ----
// Purpose: constants for the boot channel select and bit time detect block
// Assumes: 200 MHz core clock
// Notes: all figures in cycles unless named otherwise
`ifndef BCS_MAP_VH
`define BCS_MAP_VH
`define BCS_CFG_ADDR 24'h001FFC
`define BCS_CFG_ALL_ZERO 16'h0000
`define BCS_CFG_ALL_ONE 16'hFFFF
`define BCS_SEL_BOTH 8'h03
`define BCS_SEL_UART 8'h01
`define BCS_SEL_CAN 8'h02
`define BCS_SEL_UART_BIT 0
`define BCS_SEL_CAN_BIT 1
`define BCS_CAN_RECESSIVE_STOP 3'h5
`define BCS_CAN_BIT_SPAN 24'h00001D
`define BCS_MAX_ERR_TICKS 6
`define BCS_TMR_W 24
`endif

// ---- core/bcs_sync.v ----
// Purpose: two flop synchroniser for the receive pins
// Assumes: line idles high
// Notes: first flop is read only by the second
`timescale 1ns/10ps
module bcs_sync (
  input wire CLK_IN,     // core clock
  input wire RST_N_IN,   // async reset, active low
  input wire D_IN,       // asynchronous pin
  output reg Q_OUT       // synchronised level
);
  reg meta_q;
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      meta_q <= 1'b1;
      Q_OUT <= 1'b1;
    end else begin
      meta_q <= D_IN;
      Q_OUT <= meta_q;
    end
  end
endmodule

// ---- core/bcs_top.v ----
// Purpose: boot channel selection and host bit time measurement
// Assumes: config word is fetched through a simple read port; pins idle high
// Notes: timer resolution is one core clock
//   can wins when both armed lines fall in the same cycle
//   pins pass two flops, so each edge is seen two cycles late; both ends of a span shift alike
//   the timer saturates instead of wrapping when a line stays low
//   counts are exact, well inside the 6 tick polling error budget
//   the config word is fetched only when the signature check fails
//   the can divide by 29 is one wide combinational path, used once per session
//   selections and results stand until the next reset
// Contract
// - in boot mode both receive lines are watched and a low level starts the timer, a high level stops it.
// - the zero frame shows as five runs of 5 dominant and 1 recessive, then 4D, 1R, 1D and 11R.
// - on CAN the timer runs from the first dominant edge to the fifth recessive bit, spanning 29 bit times.
// - the timer counts one core cycle per tick and the result carries at most 6 ticks of error.
// - a start of frame low on the CAN line selects the CAN loader, otherwise the UART line is awaited.
// - when no alternate boot signature is good, the configuration word at 00'1FFCh is read again.
// - a word of 0000h or FFFFh falls back to the standard boot watching both channels.
// - otherwise the high byte is ignored, bit 0 arms the UART line and bit 1 arms the CAN line.
// - low byte 03 arms both, 01 the UART only, 02 the CAN only, and any other value hangs forever.
`timescale 1ns/10ps
`include "bcs_map.vh"
module bcs_top (
  input wire CLK_IN,                       // core clock, 200 MHz
  input wire RST_N_IN,                     // async reset, active low
  input wire BOOT_START_IN,                // pulse: enter boot loader mode
  input wire SIG_OK_IN,                    // level: alternate boot signature good
  input wire UART_RX_LINE_IN,              // uart receive pin
  input wire CAN_RX_LINE_IN,               // can receive pin
  output reg CFG_RD_REQ_OUT,               // config word read request
  output wire [23:0] CFG_RD_ADDR_OUT,      // config word address
  input wire CFG_RD_ACK_IN,                // pulse: read data valid
  input wire [15:0] CFG_RD_DATA_IN,        // config word
  output reg SEL_UART_OUT,                 // uart channel selected
  output reg SEL_CAN_OUT,                  // can channel selected
  output reg DONE_OUT,                     // measurement complete
  output reg HANG_OUT,                     // invalid config, endless loop
  output reg [`BCS_TMR_W-1:0] TICKS_OUT,   // measured interval in core cycles
  output reg [`BCS_TMR_W-1:0] BIT_TIME_OUT // derived bit time in core cycles
);
  // ==========================================================
  // states
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_READ = 7'h02;
  localparam [6:0] ST_WAIT = 7'h04;
  localparam [6:0] ST_UART = 7'h08;
  localparam [6:0] ST_CAN = 7'h10;
  localparam [6:0] ST_DONE = 7'h20;
  localparam [6:0] ST_HANG = 7'h40;
  localparam [`BCS_TMR_W-1:0] SPAN = `BCS_CAN_BIT_SPAN;

  reg [6:0] state_q;
  reg arm_uart_q;
  reg arm_can_q;
  reg can_prev_q;
  reg [2:0] rec_cnt_q;
  reg [`BCS_TMR_W-1:0] tmr_q;

  // synchronised pin levels
  wire [1:0] line_raw;
  wire [1:0] line_s;
  wire uart_s;
  wire can_s;
  wire can_rise;
  wire can_last;
  wire tmr_max;
  wire [`BCS_TMR_W-1:0] tmr_inc;

  // config word decode results
  reg cfg_valid;
  reg cfg_arm_uart;
  reg cfg_arm_can;

  assign CFG_RD_ADDR_OUT = `BCS_CFG_ADDR;

  // ==========================================================
  // pin synchronisers
  // bit 0 carries the uart line, bit 1 the can line
  assign line_raw = {CAN_RX_LINE_IN, UART_RX_LINE_IN};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      bcs_sync u_sync (
        .CLK_IN(CLK_IN),
        .RST_N_IN(RST_N_IN),
        .D_IN(line_raw[gi]),
        .Q_OUT(line_s[gi])
      );
    end
  endgenerate
  assign uart_s = line_s[0];
  assign can_s = line_s[1];

  // ==========================================================
  // config word decode
  always @* begin
    cfg_valid = 1'b0;
    cfg_arm_uart = 1'b0;
    cfg_arm_can = 1'b0;
    if (CFG_RD_DATA_IN == `BCS_CFG_ALL_ZERO || CFG_RD_DATA_IN == `BCS_CFG_ALL_ONE) begin
      // standard boot: both channels
      cfg_valid = 1'b1;
      cfg_arm_uart = 1'b1;
      cfg_arm_can = 1'b1;
    end else if (CFG_RD_DATA_IN[7:0] == `BCS_SEL_BOTH ||
                 CFG_RD_DATA_IN[7:0] == `BCS_SEL_UART ||
                 CFG_RD_DATA_IN[7:0] == `BCS_SEL_CAN) begin
      // high byte plays no part here
      cfg_valid = 1'b1;
      cfg_arm_uart = CFG_RD_DATA_IN[`BCS_SEL_UART_BIT];
      cfg_arm_can = CFG_RD_DATA_IN[`BCS_SEL_CAN_BIT];
    end
  end

  // ==========================================================
  // timer step and can edge detect
  // saturate rather than wrap, so a line stuck low never reports a short interval
  assign tmr_max = &tmr_q;
  assign tmr_inc = tmr_max ? tmr_q : tmr_q + {{(`BCS_TMR_W-1){1'b0}}, 1'b1};
  // a rising edge ends each dominant run; the fifth one is the stop point
  assign can_rise = can_s && !can_prev_q;
  assign can_last = can_rise && (rec_cnt_q == `BCS_CAN_RECESSIVE_STOP - 3'h1);

  // ==========================================================
  // control
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= ST_IDLE;
      arm_uart_q <= 1'b0;
      arm_can_q <= 1'b0;
      can_prev_q <= 1'b1;
      rec_cnt_q <= 3'h0;
      tmr_q <= {`BCS_TMR_W{1'b0}};
      CFG_RD_REQ_OUT <= 1'b0;
      SEL_UART_OUT <= 1'b0;
      SEL_CAN_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      HANG_OUT <= 1'b0;
      TICKS_OUT <= {`BCS_TMR_W{1'b0}};
      BIT_TIME_OUT <= {`BCS_TMR_W{1'b0}};
    end else begin
      can_prev_q <= can_s;
      case (state_q)
        ST_IDLE: begin
          if (BOOT_START_IN) begin
            if (SIG_OK_IN) begin
              // standard boot: both channels
              arm_uart_q <= 1'b1;
              arm_can_q <= 1'b1;
              state_q <= ST_WAIT;
            end else begin
              CFG_RD_REQ_OUT <= 1'b1;
              state_q <= ST_READ;
            end
          end
        end
        ST_READ: begin
          if (CFG_RD_ACK_IN) begin
            CFG_RD_REQ_OUT <= 1'b0;
            if (cfg_valid) begin
              arm_uart_q <= cfg_arm_uart;
              arm_can_q <= cfg_arm_can;
              state_q <= ST_WAIT;
            end else begin
              HANG_OUT <= 1'b1;
              state_q <= ST_HANG;
            end
          end
        end
        ST_WAIT: begin
          tmr_q <= {`BCS_TMR_W{1'b0}};
          rec_cnt_q <= 3'h0;
          // can checked first, so it wins a tie
          if (arm_can_q && !can_s) begin
            SEL_CAN_OUT <= 1'b1;
            tmr_q <= {{(`BCS_TMR_W-1){1'b0}}, 1'b1};
            state_q <= ST_CAN;
          end else if (arm_uart_q && !uart_s) begin
            SEL_UART_OUT <= 1'b1;
            tmr_q <= {{(`BCS_TMR_W-1){1'b0}}, 1'b1};
            state_q <= ST_UART;
          end
        end
        ST_UART: begin
          if (uart_s) begin
            TICKS_OUT <= tmr_q;
            BIT_TIME_OUT <= tmr_q;
            DONE_OUT <= 1'b1;
            state_q <= ST_DONE;
          end else begin
            tmr_q <= tmr_inc;
          end
        end
        ST_CAN: begin
          if (can_last) begin
            TICKS_OUT <= tmr_q;
            BIT_TIME_OUT <= tmr_q / SPAN;
            DONE_OUT <= 1'b1;
            state_q <= ST_DONE;
          end else begin
            if (can_rise) begin
              rec_cnt_q <= rec_cnt_q + 3'h1;
            end
            tmr_q <= tmr_inc;
          end
        end
        ST_DONE: begin
          state_q <= ST_DONE;
        end
        ST_HANG: begin
          state_q <= ST_HANG;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- test/bcs_host.sv ----
// Purpose: boot host and config memory model
// Assumes: both lines idle high
// Notes: read answered after dly waiting cycles
`timescale 1ns/10ps
module bcs_host (
  input wire clk_in, // core clock
  input wire req_in, // config read request
  output reg ack_out = 1'b0, // read ack pulse
  output reg [15:0] data_out = 16'h0000, // read word
  output reg uart_out = 1'b1, // uart line
  output reg can_out = 1'b1 // can line
);
  reg [15:0] cfg = 16'h0000;
  int dly = 0;
  int cnt = 0;
  always @(posedge clk_in) begin
    ack_out <= 1'b0;
    data_out <= ~data_out;
    cnt <= (req_in && !ack_out) ? cnt + 1 : 0;
    if (req_in && !ack_out && cnt >= dly) begin
      ack_out <= 1'b1;
      data_out <= cfg;
    end
  end
  task automatic uart_low(input int n);
    @(posedge clk_in) uart_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    uart_out <= 1'b1;
  endtask
  // zero frame as dominant and recessive runs
  task automatic can_frame(input int bt);
    int runs[14] = '{5, 1, 5, 1, 5, 1, 5, 1, 5, 1, 4, 1, 1, 11};
    for (int i = 0; i < 14; i++) begin
      @(posedge clk_in) can_out <= i[0];
      repeat (runs[i] * bt - 1) @(posedge clk_in);
    end
  endtask
endmodule

// ---- test/bcs_props.sv ----
// Purpose: assertions on the boot channel select ports
// Assumes: pins idle high, one session per reset
// Notes: bound to every bcs_top
`timescale 1ns/10ps
module bcs_props (
  input wire CLK_IN, // core clock
  input wire RST_N_IN, // async reset, active low
  input wire BOOT_START_IN, // session start
  input wire SIG_OK_IN, // signature good
  input wire CFG_RD_REQ_OUT, // config read request
  input wire CFG_RD_ACK_IN, // config read ack
  input wire [23:0] CFG_RD_ADDR_OUT, // config read address
  input wire [15:0] CFG_RD_DATA_IN, // config word
  input wire SEL_UART_OUT, // uart selected
  input wire SEL_CAN_OUT, // can selected
  input wire DONE_OUT, // measurement done
  input wire HANG_OUT, // invalid config
  input wire [23:0] TICKS_OUT, // measured interval
  input wire [23:0] BIT_TIME_OUT // derived bit time
);
  // ====
  // decoded config word
  wire rd = CFG_RD_REQ_OUT && CFG_RD_ACK_IN;
  wire fb = CFG_RD_DATA_IN == 16'h0000 || CFG_RD_DATA_IN == 16'hFFFF;
  wire ok = CFG_RD_DATA_IN[7:0] == 8'h01 || CFG_RD_DATA_IN[7:0] == 8'h02 || CFG_RD_DATA_IN[7:0] == 8'h03;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  chk_addr_const: assert property (CFG_RD_ADDR_OUT == 24'h001FFC) else $error("bad address");
  chk_req_held: assert property (CFG_RD_REQ_OUT && !CFG_RD_ACK_IN |=> CFG_RD_REQ_OUT) else $error("req drop");
  chk_sig_noread: assert property (SIG_OK_IN && BOOT_START_IN |=> !CFG_RD_REQ_OUT [*3]) else $error("read");
  chk_bad_hangs: assert property (rd && !fb && !ok |-> ##[1:3] HANG_OUT) else $error("no hang");
  chk_good_runs: assert property (rd && (fb || ok) |=> !HANG_OUT [*8]) else $error("hang");
  chk_one_sel: assert property (!(SEL_UART_OUT && SEL_CAN_OUT)) else $error("two channels");
  chk_sel_kept: assert property (SEL_CAN_OUT || SEL_UART_OUT |=> $stable({SEL_CAN_OUT, SEL_UART_OUT}))
    else $error("sel moved");
  chk_can_div: assert property ($rose(DONE_OUT) && SEL_CAN_OUT |-> BIT_TIME_OUT == TICKS_OUT / 29)
    else $error("can bit time");
  chk_uart_bt: assert property ($rose(DONE_OUT) && SEL_UART_OUT |-> BIT_TIME_OUT == TICKS_OUT)
    else $error("uart bit time");
  cover property ($rose(HANG_OUT));
  cover property ($rose(DONE_OUT) && SEL_CAN_OUT);
  cover property ($rose(DONE_OUT) && SEL_UART_OUT);
endmodule
bind bcs_top bcs_props chk (
  .CLK_IN(CLK_IN),
  .RST_N_IN(RST_N_IN),
  .BOOT_START_IN(BOOT_START_IN),
  .SIG_OK_IN(SIG_OK_IN),
  .CFG_RD_REQ_OUT(CFG_RD_REQ_OUT),
  .CFG_RD_ACK_IN(CFG_RD_ACK_IN),
  .CFG_RD_ADDR_OUT(CFG_RD_ADDR_OUT),
  .CFG_RD_DATA_IN(CFG_RD_DATA_IN),
  .SEL_UART_OUT(SEL_UART_OUT),
  .SEL_CAN_OUT(SEL_CAN_OUT),
  .DONE_OUT(DONE_OUT),
  .HANG_OUT(HANG_OUT),
  .TICKS_OUT(TICKS_OUT),
  .BIT_TIME_OUT(BIT_TIME_OUT)
);

// ---- test/tb_top.sv ----
// Purpose: self-checking bench for bcs_top
// Assumes: 200 MHz clock, one session per reset
// Notes: result notes queued by the driver, popped on done or hang
`timescale 1ns/10ps
module tb_top;
  logic clk = 0, rst_n = 0, start = 0, sig = 0;
  wire req, ack, su, sc, done, hang, uart_l, can_l;
  wire [15:0] data;
  wire [23:0] ticks, bit_t;
  logic [50:0] exp_q[$];
  int num_errors = 0, checks_done = 0, u, b;
  bcs_host host (.clk_in(clk), .req_in(req), .ack_out(ack), .data_out(data), .uart_out(uart_l), .can_out(can_l));
  bcs_top DUT (.CLK_IN(clk), .RST_N_IN(rst_n), .BOOT_START_IN(start), .SIG_OK_IN(sig),
    .UART_RX_LINE_IN(uart_l), .CAN_RX_LINE_IN(can_l), .CFG_RD_REQ_OUT(req),
    .CFG_RD_ADDR_OUT(), .CFG_RD_ACK_IN(ack), .CFG_RD_DATA_IN(data), .SEL_UART_OUT(su),
    .SEL_CAN_OUT(sc), .DONE_OUT(done), .HANG_OUT(hang), .TICKS_OUT(ticks), .BIT_TIME_OUT(bit_t));
  initial forever #2.5 clk = ~clk;
  task check(input logic [50:0] seen, input logic [50:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge done or posedge hang) begin
    #1;
    check({hang, sc, su, bit_t, ticks}, exp_q.pop_front());
  end
  // ====
  // one boot session: can frame first, then uart low
  task automatic run(input logic [15:0] cfg, input logic s, input int un, bt, input logic [50:0] exp);
    @(posedge clk) rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    host.cfg = cfg;
    host.dly = $urandom % 4;
    sig <= s;
    exp_q.push_back(exp);
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    repeat (8) @(posedge clk);
    if (bt > 0) host.can_frame(bt);
    if (un > 0) host.uart_low(un);
    repeat (30) @(posedge clk);
  endtask
  initial begin
    void'($urandom(22));
    u = 5 + $urandom % 20;
    b = 3 + $urandom % 6;
    run(16'hA501, 0, u, b, {3'b001, 24'(u), 24'(u)});
    run(16'h5503, 0, u, b, {3'b010, 24'(b), 24'(29 * b)});
    run(16'h0002, 0, 0, b + 1, {3'b010, 24'(b + 1), 24'(29 * (b + 1))});
    run(16'h0000, 0, u, 0, {3'b001, 24'(u), 24'(u)});
    run(16'hFFFF, 0, 0, b, {3'b010, 24'(b), 24'(29 * b)});
    run(16'h0004, 0, u, b, {3'b100, 48'h000000000000});
    run(16'h0004, 1, u, 0, {3'b001, 24'(u), 24'(u)});
    check(51'(exp_q.size()), 51'h0000000000000);
    give_verdict;
  end
  initial begin
    #50000;
    num_errors++;
    give_verdict;
  end
endmodule
